// >>> dv/core_feeder.sv
// core_feeder.sv : decoder and internal bus model offering instructions
`timescale 1ns/1ns
module core_feeder (
	input  wire logic       clk,          // core clock
	input  wire logic       instr_ready,  // unit idle
	output logic            instr_valid,  // instruction offered
	output logic      [7:0] opcode,       // instruction byte
	output logic      [7:0] bank_operand, // bank register value
	output logic      [7:0] bus_operand,  // location data
	output logic      [7:0] imm_operand   // immediate byte
);
	// nothing offered at start
	initial begin
		instr_valid = 1'b0;
		{opcode, bank_operand, bus_operand, imm_operand} = 32'h5AA55AA5;
	end
	// hold the offer until an edge sees ready high
	task automatic offer(input logic [7:0] op, bk, bs, im);
		instr_valid = 1'b1;
		{opcode, bank_operand, bus_operand, imm_operand} = {op, bk, bs, im};
		// ready is settled one step after an edge; the next edge takes it
		while (instr_ready !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
	endtask : offer
	// released lines show the inverse, never a stale copy
	task automatic idle;
		instr_valid = 1'b0;
		{opcode, bank_operand, bus_operand, imm_operand} =
			~{opcode, bank_operand, bus_operand, imm_operand};
	endtask : idle
endmodule : core_feeder

// >>> dv/tb_top.sv
// tb_top.sv : self-checking bench of the arithmetic logic unit
`timescale 1ns/1ns
module tb_top;
	import alu_pkg::*;
	typedef struct {int t; int n; logic [7:0] a, b; logic cy;
		logic [9:0] r;} note_t;
	logic clk, rst_n, instr_valid, instr_ready, pri_wr, sec_wr, flags_wr;
	logic result_valid, result_to_bank, instr_done, mc;
	logic [7:0] opcode, bank_operand, bus_operand, imm_operand, sfr_wdata;
	logic [7:0] primary_operand, second_operand, program_flags_word;
	logic [7:0] result_data, ma, mb;
	int n_errors = 0, tests_run = 0, cyc = 0, k;
	note_t q[$];
	logic [7:0] ops [43] = '{8'h28, 8'h3A, 8'h9F, 8'h24, 8'h35, 8'h96,
		8'h58, 8'h4C, 8'h6F, 8'h54, 8'h45, 8'h67, 8'hE9, 8'hE5, 8'h74,
		8'h04, 8'h14, 8'h0B, 8'h1C, 8'h05, 8'h17, 8'h23, 8'h33, 8'h03,
		8'h13, 8'hC4, 8'hE4, 8'hF4, 8'hA4, 8'h84, 8'h52, 8'h53, 8'h42,
		8'h43, 8'h62, 8'h63, 8'hF8, 8'hA9, 8'h7A, 8'hF5, 8'h8D, 8'h85, 8'h86};
	int cnt [43] = '{1, 1, 1, 2, 2, 2, 1, 1, 1, 2, 2, 2, 1, 2, 2, 1, 1, 2, 2,
		3, 3, 1, 1, 1, 1, 1, 1, 1, 5, 5, 3, 4, 3, 4, 3, 4, 2, 4, 2, 3, 3, 4, 4};

	alu_core u_alu_core (.clk, .rst_n, .instr_valid, .instr_ready, .opcode,
		.bank_operand, .bus_operand, .imm_operand, .sfr_wdata, .pri_wr,
		.sec_wr, .flags_wr, .primary_operand, .second_operand,
		.program_flags_word, .result_data, .result_valid, .result_to_bank,
		.instr_done);
	core_feeder u_core_feeder (.clk, .instr_ready, .instr_valid, .opcode,
		.bank_operand, .bus_operand, .imm_operand);

	// expected {carry, second, primary} after one instruction
	function automatic logic [16:0] model(input logic [7:0] op, a, b, bk,
		bs, im, input logic c);
		logic [8:0] s;
		logic [7:0] x, na, nb;
		logic nc;
		x = op[3] ? bk : (op[2:0] == 3'h4 ? im : bs);
		{nc, nb, na} = {c, b, a};
		case (op)
			8'h04: na = a + 8'h01;
			8'h14: na = a - 8'h01;
			8'h23: na = {a[6:0], a[7]};
			8'h03: na = {a[0], a[7:1]};
			8'h33: {nc, na} = {a, c};
			8'h13: {na, nc} = {c, a};
			8'hC4: na = {a[3:0], a[7:4]};
			8'hE4: na = 8'h00;
			8'hF4: na = ~a;
			8'h74: na = im;
			8'hA4: {nc, nb, na} = {1'b0, 16'(a * b)};
			8'h84: {nc, nb, na} = (b == 8'h00) ? {1'b0, b, a} :
				{1'b0, a % b, a / b};
			8'hD4: begin
				s = {1'b0, a} + ((a[3:0] > 4'h9) ? 9'h006 : 9'h000);
				if (c || s[8] || s[7:4] > 4'h9) s = s + 9'h060;
				{nc, na} = {c | s[8], s[7:0]};
			end
			default: if (op[3] || op[2]) case (op[7:4])
				4'h2: {nc, na} = {1'b0, a} + {1'b0, x};
				4'h3: {nc, na} = {1'b0, a} + {1'b0, x} + {8'h00, c};
				4'h9: {nc, na} = {1'b0, a} - {1'b0, x} - {8'h00, c};
				4'h4: na = a | x;
				4'h5: na = a & x;
				4'h6: na = a ^ x;
				4'hE: na = x;
				default: na = a;
			endcase
		endcase
		return {nc, nb, na};
	endfunction : model

	// expected bus result {to bank, valid, data} of location targets
	function automatic logic [9:0] res(input logic [7:0] op, a, bk, bs, im);
		logic [7:0] y;
		y = op[0] ? im : a;
		case (op)
			8'h52, 8'h53: return {2'b01, bs & y};
			8'h42, 8'h43: return {2'b01, bs | y};
			8'h62, 8'h63: return {2'b01, bs ^ y};
			8'h05, 8'h06, 8'h07: return {2'b01, bs + 8'h01};
			8'h15, 8'h16, 8'h17: return {2'b01, bs - 8'h01};
			8'hF5: return {2'b01, a};
			8'h85, 8'h86, 8'h87: return {2'b01, bs};
			default: case (op[7:3])
				5'h01: return {2'b11, bk + 8'h01};
				5'h03: return {2'b11, bk - 8'h01};
				5'h0F: return {2'b11, im};
				5'h11: return {2'b01, bk};
				5'h15: return {2'b11, bs};
				5'h1F: return {2'b11, a};
				default: return 10'h000;
			endcase
		endcase
	endfunction : res

	task automatic check(input string what, input logic [15:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("errors %0d of %0d checks", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	// core write while the unit is idle
	task automatic wr(input int sel, input logic [7:0] d);
		while (q.size() != 0) begin
			@(posedge clk);
			#1;
		end
		sfr_wdata = d;
		{pri_wr, sec_wr, flags_wr} = 3'b100 >> sel;
		@(posedge clk);
		#1;
		{pri_wr, sec_wr, flags_wr} = 3'b000;
	endtask : wr

	// offer one instruction and note what must come of it
	task automatic run(input logic [7:0] op, input int n);
		logic [7:0] bk, bs, im;
		note_t e;
		bk = 8'($urandom);
		bs = 8'($urandom);
		im = 8'($urandom);
		{e.cy, e.b, e.a} = model(op, ma, mb, bk, bs, im, mc);
		e.r = res(op, ma, bk, bs, im);
		u_core_feeder.offer(op, bk, bs, im);
		e.t = cyc - 1;
		e.n = n;
		{mc, mb, ma} = {e.cy, e.b, e.a};
		q.push_back(e);
	endtask : run

	// clock, 40 ns period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// cycle count and hang limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	// compare each completion with the oldest note
	always @(posedge clk) if (instr_done === 1'b1) begin : mon
		note_t e;
		if (q.size() == 0) check("spurious done", 16'h1, 16'h0);
		else begin
			e = q.pop_front();
			check("cycles", 16'(cyc - e.t), 16'(e.n));
			check("primary", primary_operand, e.a);
			check("second", second_operand, e.b);
			check("carry", program_flags_word[FLAG_CY], e.cy);
			check("parity", program_flags_word[FLAG_P], ^e.a);
			if (e.r[8]) check("bus result", {result_to_bank, result_valid,
				result_data}, e.r);
			else check("bus idle", result_valid, 1'b0);
		end
	end

	// main sequence
	initial begin
		rst_n = 1'b0;
		{pri_wr, sec_wr, flags_wr, sfr_wdata} = 11'h000;
		{mc, mb, ma} = 17'h00000;
		void'($urandom(32'h0DFF));
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		check("ready", instr_ready, 1'b1);
		check("flags", program_flags_word, {FLAGS_RST, 1'b0});
		wr(2, 8'h00);
		wr(0, 8'h9A);
		wr(1, 8'h07);
		{mb, ma} = 16'h079A;
		run(8'hD4, 1);
		foreach (ops[i]) run(ops[i], cnt[i]);
		repeat (300) begin
			k = $urandom_range(42);
			if ($urandom_range(3) == 0) begin
				u_core_feeder.idle();
				@(posedge clk);
				#1;
			end
			run(ops[k], cnt[k]);
		end
		u_core_feeder.idle();
		wr(2, 8'h00);
		tally_and_finish();
	end
endmodule : tb_top

// >>> hdl/alu_core.sv
// alu_core.sv : 8-bit arithmetic logic unit with per-opcode cycle timing
`timescale 1ns/1ns
module alu_core
	import alu_pkg::*;
(
	input  wire logic       clk,                // core clock, 25 MHz
	input  wire logic       rst_n,              // async reset, active low
	input  wire logic       instr_valid,        // opcode and operands offered
	output logic            instr_ready,        // idle, opcode can be taken
	input  wire logic [7:0] opcode,             // instruction byte
	input  wire logic [7:0] bank_operand,       // selected bank register
	input  wire logic [7:0] bus_operand,        // direct or indirect data
	input  wire logic [7:0] imm_operand,        // immediate data byte
	input  wire logic [7:0] sfr_wdata,          // core write data
	input  wire logic       pri_wr,             // write primary operand
	input  wire logic       sec_wr,             // write second operand
	input  wire logic       flags_wr,           // write flags word
	output logic      [7:0] primary_operand,    // primary operand register
	output logic      [7:0] second_operand,     // second operand register
	output logic      [7:0] program_flags_word, // flags word with parity
	output logic      [7:0] result_data,        // result driven to the bus
	output logic            result_valid,       // result_data is new
	output logic            result_to_bank,     // target is a bank register
	output logic            instr_done          // instruction completed
);

	alu_state_t state_reg;
	alu_state_t state_next;
	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;
	logic [7:0] primary_operand_reg;
	logic [7:0] second_operand_reg;
	logic [7:1] flags_reg;
	logic [7:1] flags_next;
	logic [7:0] op_reg;
	logic [7:0] bank_reg;
	logic [7:0] bus_reg;
	logic [7:0] imm_reg;
	logic [7:0] out_reg;
	logic       out_valid_reg;
	logic       out_bank_reg;
	logic       done_reg;

	// instruction length in core clocks per opcode
	function automatic logic [2:0] cycles_of(input logic [7:0] op);
		logic [2:0] c;
		c = CYC_SHORT;
		casez (op)
			OP_PRODUCT, OP_QUOTIENT: c = CYC_PRODUCT;
			OP_STEP_UP_PRI, OP_STEP_DN_PRI, OP_ROT_L, OP_ROT_LC,
			OP_ROT_R, OP_ROT_RC, OP_SWAP, OP_ZERO, OP_INVERT,
			OP_DEC_ADJ: c = CYC_SHORT;
			8'b000?1???: c = CYC_FETCH;
			8'b000?0101,
			8'b000?011?: c = CYC_RMW;
			8'b00101???, 8'b00111???, 8'b10011???,
			8'b01001???, 8'b01011???, 8'b01101???,
			8'b11101???: c = CYC_SHORT;
			8'b001001??, 8'b001101??, 8'b100101??,
			8'b010001??, 8'b010101??, 8'b011001??,
			8'b111001??: c = CYC_FETCH;
			8'b01??0010: c = CYC_RMW;
			8'b01??0011: c = CYC_LONG;
			OP_LD_PRI_IMM: c = CYC_FETCH;
			8'b11111???, 8'b01111???: c = CYC_FETCH;
			8'b10101???: c = CYC_LONG;
			OP_ST_PRI_DIR, 8'b10001???: c = CYC_RMW;
			OP_DIR_DIR, 8'b1000011?: c = CYC_LONG;
			default: c = CYC_SHORT;
		endcase
		return c;
	endfunction : cycles_of

	// sequencer: one clock per instruction cycle
	wire       exec      = state_reg == ST_EXEC;
	wire       accept    = instr_valid && state_reg == ST_IDLE;
	wire [2:0] new_cyc   = cycles_of(opcode);
	wire       commit    = (accept && new_cyc == CYC_SHORT) ||
		(exec && cnt_reg == 3'h0);
	assign state_next = (accept && new_cyc != CYC_SHORT) ? ST_EXEC :
		(exec && cnt_reg == 3'h0) ? ST_IDLE : state_reg;
	assign cnt_next = accept ? new_cyc - 3'h2 :
		(exec && cnt_reg != 3'h0) ? cnt_reg - 3'h1 : cnt_reg;

	// operands live at the taking edge, held while the count runs
	wire [7:0] cur_op   = exec ? op_reg : opcode;
	wire [7:0] cur_bank = exec ? bank_reg : bank_operand;
	wire [7:0] cur_bus  = exec ? bus_reg : bus_operand;
	wire [7:0] cur_imm  = exec ? imm_reg : imm_operand;
	wire [3:0] hi       = cur_op[7:4];
	wire [3:0] lo       = cur_op[3:0];
	wire [7:0] pri      = primary_operand_reg;
	wire [7:0] sec      = second_operand_reg;
	wire       cy       = flags_reg[FLAG_CY];

	// operand group decode
	wire src_bank  = lo[3];
	wire src_imm   = lo == 4'h4;
	wire alu_src   = lo[3] || lo[3:2] == 2'b01;
	wire grp_add   = alu_src && (hi == GRP_ADD || hi == GRP_ADD_WITH_CARRY_OP);
	wire grp_subtract_borrow_op  = alu_src && hi == GRP_SUBTRACT_BORROW_OP;
	wire grp_logic = hi == GRP_AND || hi == GRP_OR || hi == GRP_XOR;
	wire logic_pri = grp_logic && alu_src;
	wire logic_mem = grp_logic && lo[3:1] == 3'b001;
	wire ld_pri    = (hi == GRP_LD_PRI && alu_src && !src_imm) ||
		cur_op == OP_LD_PRI_IMM;
	wire step_pri  = cur_op == OP_STEP_UP_PRI ||
		cur_op == OP_STEP_DN_PRI;
	wire step_oth  = alu_src && !src_imm &&
		(hi == GRP_STEP_UP || hi == GRP_STEP_DN);
	wire to_bank   = src_bank && (hi == GRP_BANK_PR ||
		hi == GRP_BANK_DR || hi == GRP_BANK_IM);
	wire to_dir    = cur_op == OP_ST_PRI_DIR || cur_op == OP_DIR_DIR ||
		cur_op[7:1] == 7'b1000011 || (hi == GRP_DIR_BNK && src_bank);

	// second operand: bank register, immediate byte or bus data
	wire [7:0] y = src_bank ? cur_bank : src_imm ? cur_imm : cur_bus;

	// unsigned add and subtract, carry feeds in as the low bit
	wire       cin     = hi == GRP_ADD_WITH_CARRY_OP ? cy : 1'b0;
	wire [8:0] sum     = {1'b0, pri} + {1'b0, y} + {8'h00, cin};
	wire [4:0] sum_lo  = {1'b0, pri[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
	wire       sum_ov  = pri[7] == y[7] && sum[7] != pri[7];
	wire [8:0] diff    = {1'b0, pri} - {1'b0, y} - {8'h00, cy};
	wire [4:0] diff_lo = {1'b0, pri[3:0]} - {1'b0, y[3:0]} - {4'h0, cy};
	wire       diff_ov = pri[7] != y[7] && diff[7] != pri[7];

	// bitwise operations, into the primary or into a direct location
	wire [7:0] lx = logic_mem ? cur_bus : pri;
	wire [7:0] ly = logic_mem ? (lo[0] ? cur_imm : pri) : y;
	wire [7:0] logic_res = hi == GRP_AND ? lx & ly :
		hi == GRP_OR ? lx | ly : lx ^ ly;

	// step up or down of any 8-bit location
	wire [7:0] step_in  = step_pri ? pri : y;
	wire [7:0] step_res = hi == GRP_STEP_UP ?
		step_in + 8'h01 : step_in - 8'h01;

	// value moved out to a bank register or direct location
	wire [7:0] move_val = (hi == GRP_BANK_PR || cur_op == OP_ST_PRI_DIR) ?
		pri : hi == GRP_BANK_IM ? cur_imm :
		hi == GRP_DIR_BNK && src_bank ? cur_bank : cur_bus;

	wire [15:0] product;
	wire [7:0]  quotient;
	wire [7:0]  remainder;
	wire        div_zero;
	wire [7:0]  dec_val;
	wire        dec_cy;

	alu_prod_quot #(
		.W         (8)
	) u_prod_quot (
		.dividend  (pri),
		.divisor   (sec),
		.product   (product),
		.quotient  (quotient),
		.remainder (remainder),
		.div_zero  (div_zero)
	);

	alu_decimal_fix u_decimal_fix (
		.value_in  (pri),
		.carry_in  (cy),
		.aux_in    (flags_reg[FLAG_AC]),
		.value_out (dec_val),
		.carry_out (dec_cy)
	);

	// result and flag selection for the opcode being completed
	logic [7:0] res_pri;
	logic [7:0] res_sec;
	logic [7:0] res_out;
	logic       wr_pri;
	logic       wr_sec;
	logic       wr_out;
	logic       cy_n;
	logic       ac_n;
	logic       ov_n;
	always_comb begin
		res_pri = pri;
		res_sec = sec;
		res_out = 8'h00;
		wr_pri  = 1'b0;
		wr_sec  = 1'b0;
		wr_out  = 1'b0;
		cy_n    = cy;
		ac_n    = flags_reg[FLAG_AC];
		ov_n    = flags_reg[FLAG_OV];
		if (grp_add) begin
			res_pri = sum[7:0];
			cy_n    = sum[8];
			ac_n    = sum_lo[4];
			ov_n    = sum_ov;
			wr_pri  = 1'b1;
		end else if (grp_subtract_borrow_op) begin
			res_pri = diff[7:0];
			cy_n    = diff[8];
			ac_n    = diff_lo[4];
			ov_n    = diff_ov;
			wr_pri  = 1'b1;
		end else if (logic_pri) begin
			res_pri = logic_res;
			wr_pri  = 1'b1;
		end else if (logic_mem) begin
			res_out = logic_res;
			wr_out  = 1'b1;
		end else if (ld_pri) begin
			res_pri = y;
			wr_pri  = 1'b1;
		end else if (step_pri) begin
			res_pri = step_res;
			wr_pri  = 1'b1;
		end else if (step_oth) begin
			res_out = step_res;
			wr_out  = 1'b1;
		end else if (to_bank || to_dir) begin
			res_out = move_val;
			wr_out  = 1'b1;
		end else begin
			wr_pri = 1'b1;
			case (cur_op)
				OP_ROT_L:   res_pri = {pri[6:0], pri[7]};
				OP_ROT_R:   res_pri = {pri[0], pri[7:1]};
				OP_ROT_LC: begin
					res_pri = {pri[6:0], cy};
					cy_n    = pri[7];
				end
				OP_ROT_RC: begin
					res_pri = {cy, pri[7:1]};
					cy_n    = pri[0];
				end
				OP_SWAP:    res_pri = {pri[3:0], pri[7:4]};
				OP_ZERO:    res_pri = 8'h00;
				OP_INVERT:  res_pri = ~pri;
				OP_DEC_ADJ: begin
					res_pri = dec_val;
					cy_n    = dec_cy;
				end
				OP_PRODUCT: begin
					res_pri = product[7:0];
					res_sec = product[15:8];
					wr_sec  = 1'b1;
					cy_n    = 1'b0;
					ov_n    = product[15:8] != 8'h00;
				end
				OP_QUOTIENT: begin
					res_pri = div_zero ? pri : quotient;
					res_sec = div_zero ? sec : remainder;
					wr_sec  = 1'b1;
					cy_n    = 1'b0;
					ov_n    = div_zero;
				end
				default:    wr_pri = 1'b0;
			endcase
		end
	end

	// unit results win over a core write in the same clock
	assign flags_next = commit ? {cy_n, ac_n, flags_reg[5:3], ov_n,
		flags_reg[1]} : flags_wr ? sfr_wdata[7:1] : flags_reg;

	// sequencer and operand capture
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 3'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			op_reg   <= 8'h00;
			bank_reg <= 8'h00;
			bus_reg  <= 8'h00;
			imm_reg  <= 8'h00;
		end else if (accept) begin
			op_reg   <= opcode;
			bank_reg <= bank_operand;
			bus_reg  <= bus_operand;
			imm_reg  <= imm_operand;
		end
	end

	// primary, second and flags registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			primary_operand_reg <= PRI_RST;
			second_operand_reg  <= SEC_RST;
			flags_reg           <= FLAGS_RST;
		end else begin
			if (commit && wr_pri) primary_operand_reg <= res_pri;
			else if (pri_wr) primary_operand_reg <= sfr_wdata;
			if (commit && wr_sec) second_operand_reg <= res_sec;
			else if (sec_wr) second_operand_reg <= sfr_wdata;
			flags_reg <= flags_next;
		end
	end

	// bus result and completion pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_reg       <= 8'h00;
			out_valid_reg <= 1'b0;
			out_bank_reg  <= 1'b0;
			done_reg      <= 1'b0;
		end else begin
			if (commit && wr_out) out_reg <= res_out;
			// bank moves and bank steps only; bank into direct is not
			if (commit && wr_out) out_bank_reg <= to_bank ||
				(step_oth && src_bank);
			out_valid_reg <= commit && wr_out;
			done_reg      <= commit;
		end
	end

	// outputs; parity is always that of the primary operand
	assign instr_ready        = state_reg == ST_IDLE;
	assign primary_operand    = primary_operand_reg;
	assign second_operand     = second_operand_reg;
	assign program_flags_word = {flags_reg, ^primary_operand_reg};
	assign result_data        = out_reg;
	assign result_valid       = out_valid_reg;
	assign result_to_bank     = out_bank_reg;
	assign instr_done         = done_reg;

	// checks of timing and results
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_product_time;
		accept && opcode == OP_PRODUCT |=> !instr_ready [*4] ##1 instr_done;
	endproperty
	a_product_time: assert property (p_product_time)
		else $error("product did not finish in five cycles");

	property p_product_value;
		accept && opcode == OP_PRODUCT && !pri_wr && !sec_wr
		##1 (!pri_wr && !sec_wr) [*4] |=>
		{second_operand, primary_operand} ==
		16'($past(primary_operand, 5)) * 16'($past(second_operand, 5));
	endproperty
	a_product_value: assert property (p_product_value)
		else $error("product value wrong");

	property p_bank_add;
		accept && opcode[7:3] == 5'b00101 && !pri_wr |=> instr_done &&
		primary_operand == 8'($past(primary_operand) + $past(bank_operand));
	endproperty
	a_bank_add: assert property (p_bank_add)
		else $error("bank add wrong or late");

	property p_mem_add_time;
		accept && opcode == 8'h25 |=> !instr_done ##1 instr_done;
	endproperty
	a_mem_add_time: assert property (p_mem_add_time)
		else $error("direct add not two cycles");

	property p_step_dir;
		accept && opcode == 8'h05 |-> ##3 instr_done && result_valid &&
		result_data == 8'($past(bus_operand, 3) + 8'h01);
	endproperty
	a_step_dir: assert property (p_step_dir)
		else $error("direct step up wrong or late");

	property p_subtract_borrow_op_carry;
		accept && opcode[7:3] == 5'b10011 && !flags_wr |=>
		program_flags_word[FLAG_CY] ==
		($past(bank_operand) + 9'($past(program_flags_word[FLAG_CY]))
		> 9'($past(primary_operand)));
	endproperty
	a_subtract_borrow_op_carry: assert property (p_subtract_borrow_op_carry)
		else $error("borrow flag wrong");

	property p_and_imm_dir;
		accept && opcode == 8'h53 |-> ##4 result_valid && instr_done;
	endproperty
	a_and_imm_dir: assert property (p_and_imm_dir)
		else $error("and into direct with immediate not four cycles");

	property p_rot_left;
		accept && opcode == OP_ROT_L && !pri_wr |=> primary_operand ==
		{$past(primary_operand[6:0]), $past(primary_operand[7])};
	endproperty
	a_rot_left: assert property (p_rot_left)
		else $error("rotate left wrong");

	property p_flags_write;
		flags_wr && !commit |=>
		program_flags_word[7:1] == $past(sfr_wdata[7:1]);
	endproperty
	a_flags_write: assert property (p_flags_write)
		else $error("core write of flags word lost");

	property p_bank_from_dir;
		accept && opcode[7:3] == 5'b10101 |-> ##4 result_valid &&
		result_to_bank && result_data == $past(bus_operand, 4);
	endproperty
	a_bank_from_dir: assert property (p_bank_from_dir)
		else $error("direct into bank wrong or late");

	property p_dir_dir;
		accept && opcode == OP_DIR_DIR |-> ##4 result_valid &&
		!result_to_bank;
	endproperty
	a_dir_dir: assert property (p_dir_dir)
		else $error("direct to direct not four cycles");

	c_product: cover property (accept && opcode == OP_PRODUCT);
	c_quot_zero: cover property (commit && cur_op == OP_QUOTIENT &&
		div_zero);
	c_busy_offer: cover property (instr_valid && !instr_ready);

endmodule : alu_core

// >>> hdl/alu_decimal_fix.sv
// alu_decimal_fix.sv : decimal adjust of the primary operand after addition
`timescale 1ns/1ns
module alu_decimal_fix
	import alu_pkg::*;
(
	input  wire logic [7:0] value_in,  // primary operand
	input  wire logic       carry_in,  // carry flag
	input  wire logic       aux_in,    // auxiliary carry flag
	output logic      [7:0] value_out, // adjusted value
	output logic            carry_out  // carry after adjust
);

	logic [8:0] low_fix;
	logic [8:0] high_fix;

	// low digit first, its carry may push the high digit past nine
	assign low_fix = (aux_in || value_in[3:0] > 4'h9) ?
		{1'b0, value_in} + 9'h006 : {1'b0, value_in};
	assign high_fix = (carry_in || low_fix[8] || low_fix[7:4] > 4'h9) ?
		low_fix + 9'h060 : low_fix;
	assign value_out = high_fix[7:0];
	// carry is only ever set here, never cleared
	assign carry_out = carry_in || low_fix[8] || high_fix[8];

endmodule : alu_decimal_fix

// >>> hdl/alu_pkg.sv
// alu_pkg.sv : constants and types of the core arithmetic logic unit
package alu_pkg;

	// core clocks spent in one instruction cycle
	localparam logic [2:0] CLK_PER_CYCLE = 3'h1;
	// instruction lengths in core clocks
	localparam logic [2:0] CYC_SHORT   = 3'h1 * CLK_PER_CYCLE;
	localparam logic [2:0] CYC_FETCH   = 3'h2 * CLK_PER_CYCLE;
	localparam logic [2:0] CYC_RMW     = 3'h3 * CLK_PER_CYCLE;
	localparam logic [2:0] CYC_LONG    = 3'h4 * CLK_PER_CYCLE;
	localparam logic [2:0] CYC_PRODUCT = 3'h5 * CLK_PER_CYCLE;

	// flag positions in the program flags word
	localparam int FLAG_CY = 7;
	localparam int FLAG_AC = 6;
	localparam int FLAG_OV = 2;
	localparam int FLAG_P  = 0;

	// values after reset
	localparam logic [7:0] PRI_RST   = 8'h00;
	localparam logic [7:0] SEC_RST   = 8'h00;
	localparam logic [7:1] FLAGS_RST = 7'h00;

	// single opcodes; the first ten work on the primary operand only
	localparam logic [7:0] OP_STEP_UP_PRI = 8'h04;
	localparam logic [7:0] OP_STEP_DN_PRI = 8'h14;
	localparam logic [7:0] OP_ROT_L       = 8'h23;
	localparam logic [7:0] OP_ROT_LC      = 8'h33;
	localparam logic [7:0] OP_ROT_R       = 8'h03;
	localparam logic [7:0] OP_ROT_RC      = 8'h13;
	localparam logic [7:0] OP_SWAP        = 8'hC4;
	localparam logic [7:0] OP_ZERO        = 8'hE4;
	localparam logic [7:0] OP_INVERT      = 8'hF4;
	localparam logic [7:0] OP_DEC_ADJ     = 8'hD4;
	localparam logic [7:0] OP_PRODUCT     = 8'hA4;
	localparam logic [7:0] OP_QUOTIENT    = 8'h84;
	localparam logic [7:0] OP_LD_PRI_IMM  = 8'h74;
	localparam logic [7:0] OP_ST_PRI_DIR  = 8'hF5;
	localparam logic [7:0] OP_DIR_DIR     = 8'h85;

	// upper opcode nibbles of the operand groups
	localparam logic [3:0] GRP_STEP_UP = 4'h0;
	localparam logic [3:0] GRP_STEP_DN = 4'h1;
	localparam logic [3:0] GRP_ADD     = 4'h2;
	localparam logic [3:0] GRP_ADD_WITH_CARRY_OP    = 4'h3;
	localparam logic [3:0] GRP_OR      = 4'h4;
	localparam logic [3:0] GRP_AND     = 4'h5;
	localparam logic [3:0] GRP_XOR     = 4'h6;
	localparam logic [3:0] GRP_BANK_IM = 4'h7;
	localparam logic [3:0] GRP_DIR_BNK = 4'h8;
	localparam logic [3:0] GRP_SUBTRACT_BORROW_OP    = 4'h9;
	localparam logic [3:0] GRP_BANK_DR = 4'hA;
	localparam logic [3:0] GRP_LD_PRI  = 4'hE;
	localparam logic [3:0] GRP_BANK_PR = 4'hF;

	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b10
	} alu_state_t;

endpackage : alu_pkg

// >>> hdl/alu_prod_quot.sv
// alu_prod_quot.sv : unsigned 8x8 product and 8/8 quotient
`timescale 1ns/1ns
module alu_prod_quot
	import alu_pkg::*;
#(
	parameter int W = 8                 // operand width
) (
	input  wire logic [W-1:0]   dividend,  // primary operand
	input  wire logic [W-1:0]   divisor,   // second operand
	output logic      [2*W-1:0] product,   // full unsigned product
	output logic      [W-1:0]   quotient,  // unsigned quotient
	output logic      [W-1:0]   remainder, // unsigned remainder
	output logic                div_zero   // divisor was zero
);

	// unsigned only; zero divisor yields zeros and a flag
	assign product   = {{W{1'b0}}, dividend} * {{W{1'b0}}, divisor};
	assign div_zero  = divisor == '0;
	assign quotient  = div_zero ? '0 : dividend / divisor;
	assign remainder = div_zero ? '0 : dividend % divisor;

endmodule : alu_prod_quot
